/* design/fpd_pkg.sv */
// Shared constants, command codes, parameter carrier and states for the
// fixed pulse drive axis.
// Assumes a single 200 MHz system clock shared by every user.
package fpd_pkg;

  // Clock rate and period of the system clock.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Period of the speed ramp step, and its length in clock cycles.
  localparam int unsigned RAMP_TICK_NS = 1000;
  localparam int unsigned RAMP_TICK_CYC =
    (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Width of counts, positions and speeds.
  localparam int unsigned POS_W = 32;

  // Width of the command code bus.
  localparam int unsigned CMD_W = 8;

  // Drive command codes.
  localparam logic [CMD_W-1:0] CMD_REL = 8'h50;
  localparam logic [CMD_W-1:0] CMD_CREL = 8'h51;
  localparam logic [CMD_W-1:0] CMD_CONT_PLUS = 8'h52;
  localparam logic [CMD_W-1:0] CMD_CONT_MINUS = 8'h53;
  localparam logic [CMD_W-1:0] CMD_ABS = 8'h54;
  localparam logic [CMD_W-1:0] CMD_DECEL_STOP = 8'h26;
  localparam logic [CMD_W-1:0] CMD_INSTANT_STOP = 8'h27;

  // Reset value and unit step of counters and accumulators.
  localparam logic [POS_W-1:0] ZERO_W = 32'h0000_0000;
  localparam logic [POS_W-1:0] ONE_W = 32'h0000_0001;

  // Drive parameters written by the host, held outside this block.
  typedef struct packed {
    logic signed [POS_W-1:0] drivePulseCount; // Count or destination.
    logic [POS_W-1:0] startSpeedValue; // Initial speed in pulses/s.
    logic [POS_W-1:0] targetSpeedValue; // Drive speed in pulses/s.
    logic [POS_W-1:0] accelDecelRate; // Speed step per ramp tick.
    logic [POS_W-1:0] decelPoint; // Manual deceleration point.
    logic [POS_W-1:0] splitInterval; // Drive pulses per split pulse.
    logic accelEn; // High for a ramped profile.
    logic manualDecel; // High to use decelPoint.
    logic splitEn; // High to emit split pulses.
  } fpd_param_t;

  // Motion states of the axis.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEL,
    ST_CONST,
    ST_DECEL
  } fpd_state_t;

endpackage

/* design/fpd_axis.sv */
// Pulse output sequencer of one motor axis: fixed and continuous driving,
// ramp profile, position counters and split pulses.
// Assumes commands, parameters and encoder strobes are synchronous to clk.
//
// Functional notes
// - Continuous drive runs until stop command/input.
// - Relative drive direction follows count sign.
// - Auto decel when remaining at or below accel pulses.
// - Fixed drive ends after all pulses emitted.
// - Code 50h starts relative drive.
// - Code 54h starts absolute drive.
// - Absolute direction/count from destination minus position.
// - Fixed drives run constant or ramped.
// - Deceleration reuses the acceleration rate.
// - Auto decel point used only in ramped fixed drives.
// - Manual mode decelerates at host point.
// - Count override only relative, same direction.
// - Speed change ignored in continuous interpolation.
// - Logical counts drive pulses, real counts encoder.
// - Split pulses every interval of drive pulses.
// - Code 51h runs opposite to count sign.
// - Codes 52h/53h drive plus/minus continuously.
`timescale 1ns/1ps
`default_nettype none

module fpd_axis (
  // Clock and synchronous active-low reset.
  input wire logic clk,
  input wire logic nrst,
  // Command write from the host.
  input wire logic cmdValid,
  input wire logic [fpd_pkg::CMD_W-1:0] cmdCode,
  // Current drive parameters and change strobes.
  input wire fpd_pkg::fpd_param_t params,
  input wire logic countWrite,
  input wire logic speedWrite,
  input wire logic contInterp,
  // External stop and encoder inputs.
  input wire logic extStop,
  input wire logic encUp,
  input wire logic encDown,
  // Drive pulse outputs.
  output logic pulsePlus,
  output logic pulseMinus,
  output logic splitPulse,
  // Status outputs.
  output logic busy,
  output logic dirMinus,
  output logic [fpd_pkg::POS_W-1:0] logicalPos,
  output logic [fpd_pkg::POS_W-1:0] realPos
);
  import fpd_pkg::*;

  // Magnitude of a 33-bit signed value, cut to the counter width.
  function automatic logic [POS_W-1:0] mag33(input logic signed [POS_W:0] v);
    logic [POS_W:0] u;
    u = v[POS_W] ? 33'(-v) : 33'(v);
    return u[POS_W-1:0];
  endfunction

  fpd_state_t state_r, state_nxt; // Motion state.
  logic busy_r; // Registered copy of state not idle.
  logic dirMinus_r; // High while moving in the minus direction.
  logic continuous_r; // High during a continuous drive.
  logic absolute_r; // High during an absolute drive.
  logic counterRel_r; // High during a counter relative drive.
  logic stopReq_r; // Decelerating stop has been requested.
  logic [POS_W-1:0] total_r; // Pulses to emit in a fixed drive.
  logic [POS_W-1:0] emitted_r; // Pulses emitted so far.
  logic [POS_W-1:0] accelPulses_r; // Pulses emitted while ramping up.
  logic [POS_W-1:0] curSpeed_r; // Present output speed.
  logic [POS_W-1:0] phase_r; // Pulse rate accumulator.
  logic [POS_W-1:0] tick_r; // Ramp tick divider.
  logic [POS_W-1:0] startSpd_r, tgtSpd_r, rate_r, decelPt_r;
  logic accelEn_r, manual_r; // Latched profile options.
  logic [POS_W-1:0] logicalPos_r, realPos_r, splitCnt_r;
  logic pulsePlus_r, pulseMinus_r, splitPulse_r;

  // Combinational helpers.
  logic [POS_W:0] phaseSum; // Accumulator plus present speed.
  logic pulseNow; // A drive pulse is emitted this cycle.
  logic rampTick; // Speed ramp step this cycle.
  logic startCmd; // An accepted drive start command.
  logic instantStop; // Stop without deceleration.
  logic decelStop; // Stop with deceleration.
  logic lastPulse; // This pulse completes the fixed drive.
  logic [POS_W-1:0] remaining; // Pulses still to emit.
  logic [POS_W-1:0] newTotal; // Count requested at start or override.
  logic newDirMinus; // Direction requested at start or override.
  logic overrideOk; // A count override is accepted.
  logic signed [POS_W:0] absDiff; // Destination minus logical position.

  // Pulse timing, stop decode and start decode.
  always_comb begin
    phaseSum = {1'b0, phase_r} + {1'b0, curSpeed_r};
    pulseNow = (state_r != ST_IDLE) && (phaseSum >= (POS_W+1)'(CLK_HZ));
    rampTick = (tick_r == POS_W'(RAMP_TICK_CYC - 1));
    remaining = total_r - emitted_r;
    lastPulse = pulseNow && !continuous_r && (emitted_r + ONE_W == total_r);
    instantStop = cmdValid && (cmdCode == CMD_INSTANT_STOP);
    decelStop = (cmdValid && (cmdCode == CMD_DECEL_STOP)) || extStop;
    absDiff = 33'(params.drivePulseCount) - 33'(signed'(logicalPos_r));
    // Direction and count from the signed count register.
    newDirMinus = params.drivePulseCount[POS_W-1];
    newTotal = mag33(33'(params.drivePulseCount));
    if (cmdValid && cmdCode == CMD_CREL) begin
      newDirMinus = !params.drivePulseCount[POS_W-1];
    end else if (cmdValid && cmdCode == CMD_ABS) begin
      newDirMinus = absDiff[POS_W];
      newTotal = mag33(absDiff);
    end else if (cmdValid && cmdCode == CMD_CONT_PLUS) begin
      newDirMinus = 1'b0;
    end else if (cmdValid && cmdCode == CMD_CONT_MINUS) begin
      newDirMinus = 1'b1;
    end
    if (countWrite && counterRel_r) begin
      newDirMinus = !params.drivePulseCount[POS_W-1];
    end
    // Fixed drives with nothing to emit do not start.
    startCmd = cmdValid && (state_r == ST_IDLE) &&
      (((cmdCode == CMD_REL || cmdCode == CMD_CREL || cmdCode == CMD_ABS) &&
        newTotal != ZERO_W) ||
       cmdCode == CMD_CONT_PLUS || cmdCode == CMD_CONT_MINUS);
    // Override only in relative kinds and only keeping direction.
    overrideOk = countWrite && (state_r != ST_IDLE) && !continuous_r &&
      !absolute_r && (newDirMinus == dirMinus_r) &&
      (newTotal != ZERO_W);
  end

  // Next motion state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (startCmd) begin
          state_nxt = params.accelEn ? ST_ACCEL : ST_CONST;
        end
      end
      ST_ACCEL, ST_CONST, ST_DECEL: begin
        if (accelEn_r && (decelStop || stopReq_r)) begin
          state_nxt = ST_DECEL;
        end else if (accelEn_r && state_r == ST_DECEL && overrideOk) begin
          state_nxt = ST_ACCEL; // Longer count ramps up again.
        end else if (accelEn_r && !continuous_r && state_r != ST_DECEL &&
                     (manual_r ? remaining <= decelPt_r
                               : remaining <= accelPulses_r)) begin
          state_nxt = ST_DECEL;
        end else if (state_r == ST_ACCEL && rampTick &&
                     curSpeed_r + rate_r >= tgtSpd_r) begin
          state_nxt = ST_CONST;
        end else if (state_r == ST_CONST && accelEn_r &&
                     curSpeed_r < tgtSpd_r) begin
          state_nxt = ST_ACCEL;
        end
        // Ending conditions override everything else.
        if (instantStop || lastPulse) begin
          state_nxt = ST_IDLE;
        end else if (decelStop && !accelEn_r) begin
          state_nxt = ST_IDLE;
        end else if (stopReq_r && rampTick && curSpeed_r <= startSpd_r) begin
          state_nxt = ST_IDLE;
        end else if (overrideOk && newTotal <= emitted_r) begin
          state_nxt = ST_IDLE; // Shortened to or below output so far.
        end
      end
    endcase
  end

  // Motion state, drive kind and latched profile.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
      dirMinus_r <= 1'b0;
      continuous_r <= 1'b0;
      absolute_r <= 1'b0;
      counterRel_r <= 1'b0;
      stopReq_r <= 1'b0;
      startSpd_r <= ZERO_W;
      rate_r <= ZERO_W;
      decelPt_r <= ZERO_W;
      accelEn_r <= 1'b0;
      manual_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r <= (state_nxt != ST_IDLE);
      if (startCmd) begin
        dirMinus_r <= newDirMinus;
        continuous_r <= (cmdCode == CMD_CONT_PLUS) ||
          (cmdCode == CMD_CONT_MINUS);
        absolute_r <= (cmdCode == CMD_ABS);
        counterRel_r <= (cmdCode == CMD_CREL);
        stopReq_r <= 1'b0;
        startSpd_r <= params.startSpeedValue;
        rate_r <= params.accelDecelRate;
        decelPt_r <= params.decelPoint;
        accelEn_r <= params.accelEn;
        manual_r <= params.manualDecel;
      end else if (state_nxt == ST_IDLE) begin
        stopReq_r <= 1'b0;
      end else if (decelStop) begin
        stopReq_r <= 1'b1;
      end
    end
  end

  // Target speed: latched at start, changeable except in interpolation.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tgtSpd_r <= ZERO_W;
    end else if (startCmd || (speedWrite && !contInterp)) begin
      tgtSpd_r <= params.targetSpeedValue;
    end
  end

  // Pulse count, emitted pulses and pulses used while ramping up.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      total_r <= ZERO_W;
      emitted_r <= ZERO_W;
      accelPulses_r <= ZERO_W;
    end else if (startCmd) begin
      total_r <= newTotal;
      emitted_r <= ZERO_W;
      accelPulses_r <= ZERO_W;
    end else begin
      if (overrideOk) begin
        total_r <= newTotal;
      end
      if (pulseNow) begin
        emitted_r <= emitted_r + ONE_W;
        if (state_r == ST_ACCEL) begin
          accelPulses_r <= accelPulses_r + ONE_W;
        end
      end
    end
  end

  // Speed ramp and pulse rate accumulator.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      curSpeed_r <= ZERO_W;
      phase_r <= ZERO_W;
      tick_r <= ZERO_W;
    end else if (state_nxt == ST_IDLE) begin
      curSpeed_r <= ZERO_W;
      phase_r <= ZERO_W;
      tick_r <= ZERO_W;
    end else begin
      tick_r <= rampTick ? ZERO_W : tick_r + ONE_W;
      phase_r <= pulseNow ? POS_W'(phaseSum - (POS_W+1)'(CLK_HZ))
                          : phaseSum[POS_W-1:0];
      if (startCmd) begin
        // Constant speed starts at drive speed, ramps at initial speed.
        curSpeed_r <= params.accelEn ? params.startSpeedValue
                                     : params.targetSpeedValue;
      end else if (!accelEn_r) begin
        curSpeed_r <= tgtSpd_r;
      end else if (rampTick && state_r == ST_ACCEL) begin
        curSpeed_r <= (curSpeed_r + rate_r >= tgtSpd_r) ?
          tgtSpd_r : curSpeed_r + rate_r;
      end else if (rampTick && state_r == ST_DECEL) begin
        // Deceleration steps by the acceleration rate.
        curSpeed_r <= (curSpeed_r <= startSpd_r + rate_r) ?
          startSpd_r : curSpeed_r - rate_r;
      end else if (rampTick && state_r == ST_CONST &&
                   curSpeed_r > tgtSpd_r) begin
        curSpeed_r <= (curSpeed_r <= tgtSpd_r + rate_r) ?
          tgtSpd_r : curSpeed_r - rate_r;
      end
    end
  end

  // Logical and real position counters.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      logicalPos_r <= ZERO_W;
      realPos_r <= ZERO_W;
    end else begin
      if (pulseNow) begin
        logicalPos_r <= dirMinus_r ? logicalPos_r - ONE_W
                                   : logicalPos_r + ONE_W;
      end
      if (encUp && !encDown) begin
        realPos_r <= realPos_r + ONE_W;
      end else if (encDown && !encUp) begin
        realPos_r <= realPos_r - ONE_W;
      end
    end
  end

  // Drive pulse outputs and split pulses.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulsePlus_r <= 1'b0;
      pulseMinus_r <= 1'b0;
      splitPulse_r <= 1'b0;
      splitCnt_r <= ZERO_W;
    end else begin
      pulsePlus_r <= pulseNow && !dirMinus_r;
      pulseMinus_r <= pulseNow && dirMinus_r;
      splitPulse_r <= 1'b0;
      if (startCmd) begin
        splitCnt_r <= ZERO_W;
      end else if (pulseNow && params.splitEn) begin
        if (splitCnt_r + ONE_W >= params.splitInterval) begin
          splitPulse_r <= 1'b1;
          splitCnt_r <= ZERO_W;
        end else begin
          splitCnt_r <= splitCnt_r + ONE_W;
        end
      end
    end
  end

  // Outputs straight from flip-flops.
  assign pulsePlus = pulsePlus_r;
  assign pulseMinus = pulseMinus_r;
  assign splitPulse = splitPulse_r;
  assign busy = busy_r;
  assign dirMinus = dirMinus_r;
  assign logicalPos = logicalPos_r;
  assign realPos = realPos_r;

  // Checks of the drive behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_rel_dir;
    startCmd && cmdCode == CMD_REL && params.drivePulseCount > 0
      |=> busy_r && !dirMinus_r &&
        total_r == $past(params.drivePulseCount);
  endproperty
  a_rel_dir: assert property (p_rel_dir)
    else $error("Relative start with positive count went wrong.");

  property p_crel_dir;
    startCmd && cmdCode == CMD_CREL && params.drivePulseCount > 0
      |=> busy_r && dirMinus_r;
  endproperty
  a_crel_dir: assert property (p_crel_dir)
    else $error("Counter relative start did not reverse direction.");

  property p_abs_start;
    startCmd && cmdCode == CMD_ABS && !absDiff[POS_W]
      |=> !dirMinus_r && absolute_r &&
        total_r == $past(params.drivePulseCount - logicalPos_r);
  endproperty
  a_abs_start: assert property (p_abs_start)
    else $error("Absolute start direction or count is wrong.");

  property p_cont_start;
    startCmd && cmdCode == CMD_CONT_MINUS |=> continuous_r && dirMinus_r;
  endproperty
  a_cont_start: assert property (p_cont_start)
    else $error("Minus continuous start went wrong.");

  property p_cont_runs;
    busy_r && continuous_r && !decelStop && !instantStop && !stopReq_r
      |=> busy_r;
  endproperty
  a_cont_runs: assert property (p_cont_runs)
    else $error("Continuous drive stopped without a stop.");

  property p_fixed_end;
    lastPulse && !startCmd |=> !busy_r ##1 !pulsePlus_r && !pulseMinus_r;
  endproperty
  a_fixed_end: assert property (p_fixed_end)
    else $error("Fixed drive did not end after its last pulse.");

  property p_auto_decel;
    state_r == ST_ACCEL && accelEn_r && !manual_r && !continuous_r &&
      remaining <= accelPulses_r && !overrideOk
      |=> state_r == ST_DECEL || state_r == ST_IDLE;
  endproperty
  a_auto_decel: assert property (p_auto_decel)
    else $error("Automatic deceleration did not begin.");

  property p_abs_no_override;
    busy_r && absolute_r && countWrite && !startCmd |=> $stable(total_r);
  endproperty
  a_abs_no_override: assert property (p_abs_no_override)
    else $error("Count changed during an absolute drive.");

  property p_interp_speed;
    contInterp && !startCmd |=> $stable(tgtSpd_r);
  endproperty
  a_interp_speed: assert property (p_interp_speed)
    else $error("Speed changed during continuous interpolation.");

  property p_logical_count;
    pulsePlus_r |-> logicalPos_r == $past(logicalPos_r) + ONE_W;
  endproperty
  a_logical_count: assert property (p_logical_count)
    else $error("Logical position missed a plus pulse.");

  c_rel_done: cover property (startCmd && cmdCode == CMD_REL ##[1:1000]
    !busy_r);
  c_decel: cover property (state_r == ST_ACCEL ##[1:1000]
    state_r == ST_DECEL);
  c_split: cover property (splitPulse_r);
endmodule

`default_nettype wire

/* verification/fpd_motor_model.sv */
// Motor driver model: turns every drive pulse into an encoder count pulse.
// Assumes the axis emits one-cycle drive pulses on the shared clock.
`timescale 1ns/1ps
`default_nettype none
module fpd_motor_model #(
  parameter int LAG = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Drive pulses from the axis.
  input wire logic pulsePlus,
  input wire logic pulseMinus,
  // Encoder pulses back to the axis.
  output logic encUp,
  output logic encDown
);
  // Delay lines standing for the shaft and encoder lag.
  logic [LAG-1:0] upLine_r;
  logic [LAG-1:0] downLine_r;
  // Shifts each pulse along, so the encoder reports it LAG cycles later.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      upLine_r <= '0;
      downLine_r <= '0;
    end else begin
      upLine_r <= {upLine_r[LAG-2:0], pulsePlus};
      downLine_r <= {downLine_r[LAG-2:0], pulseMinus};
    end
  end
  assign encUp = upLine_r[LAG-1];
  assign encDown = downLine_r[LAG-1];
endmodule
`default_nettype wire

/* verification/tb_fpd_axis.sv */
// Testbench of the axis sequencer: one task per scenario, self-checking.
// Assumes the motor model closes the encoder loop back to the axis.
`timescale 1ns/1ps
`default_nettype none
module tb_fpd_axis;
  import fpd_pkg::*;
  // Clock, reset and host-side stimulus.
  logic clk = 0;
  logic nrst = 0;
  logic cmdValid = 0;
  logic countWrite = 0;
  logic speedWrite = 0;
  logic contInterp = 0;
  logic extStop = 0;
  logic [CMD_W-1:0] cmdCode = 8'h00;
  fpd_param_t params = '0;
  // Outputs of the axis and of the motor model.
  logic pulsePlus, pulseMinus, splitPulse, busy, dirMinus, encUp, encDown;
  logic [POS_W-1:0] logicalPos, realPos, expPos;
  // Pulse counters, pulse spacing and the tallies.
  int nPlus = 0, nMinus = 0, nSplit = 0, cyc = 0, lastAt = 0, gap = 0;
  int mismatches = 0, check_count = 0;
  always #2.5 clk = ~clk;
  fpd_axis DUT (.clk(clk), .nrst(nrst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .params(params), .countWrite(countWrite),
    .speedWrite(speedWrite), .contInterp(contInterp), .extStop(extStop),
    .encUp(encUp), .encDown(encDown), .pulsePlus(pulsePlus),
    .pulseMinus(pulseMinus), .splitPulse(splitPulse), .busy(busy),
    .dirMinus(dirMinus), .logicalPos(logicalPos), .realPos(realPos));
  fpd_motor_model #(.LAG(3)) motor (.clk(clk), .nrst(nrst),
    .pulsePlus(pulsePlus), .pulseMinus(pulseMinus), .encUp(encUp),
    .encDown(encDown));
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic close_out;
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Counts pulses and keeps the spacing before the latest drive pulse.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pulsePlus || pulseMinus) begin
      gap <= cyc - lastAt;
      lastAt <= cyc;
    end
    if (pulsePlus) nPlus <= nPlus + 1;
    if (pulseMinus) nMinus <= nMinus + 1;
    if (splitPulse) begin
      nSplit <= nSplit + 1;
      chk(pulsePlus | pulseMinus, 1);
    end
  end
  // Gives a one-cycle command strobe.
  task automatic cmd(input logic [CMD_W-1:0] c);
    @(negedge clk);
    cmdValid = 1;
    cmdCode = c;
    @(negedge clk);
    cmdValid = 0;
  endtask
  // Waits for the drive to end, or for k plus pulses, under a bound.
  task automatic waitFor(input int k, input int lim);
    int i;
    i = 0;
    while ((k == 0 ? busy !== 1'b0 : nPlus < k) && i < lim) begin
      @(negedge clk);
      i++;
    end
    if (i >= lim) begin
      mismatches++;
      close_out();
    end
    // Lets the counters take in the pulse launched as busy falls.
    @(negedge clk);
  endtask
  // Runs one fixed drive and checks counts, direction and both counters.
  task automatic fixedRun(input logic [CMD_W-1:0] c,
      input logic signed [POS_W-1:0] n, input int ep, input int em);
    params.drivePulseCount = n;
    nPlus = 0;
    nMinus = 0;
    nSplit = 0;
    cmd(c);
    chk(busy, 1);
    waitFor(0, 20000);
    chk(nPlus, ep);
    chk(nMinus, em);
    expPos = expPos + ep - em;
    chk(logicalPos, expPos);
    chk(dirMinus, em > 0);
    repeat (5) @(negedge clk);
    chk(realPos, expPos);
  endtask
  // Ramped run; the spacing of the last pulses shows where decel began.
  task automatic rampRun(input logic man, input int lo, input int hi);
    params.accelEn = 1;
    params.manualDecel = man;
    params.decelPoint = 32'h0000_0002;
    fixedRun(CMD_REL, 200, 200, 0);
    chk(gap >= lo && gap <= hi, 1);
    params.accelEn = 0;
    params.manualDecel = 0;
  endtask
  // Rewrites the count mid-drive: a reversed count first, then m.
  task automatic overrideRun(input logic [CMD_W-1:0] c,
      input logic signed [POS_W-1:0] n, input int m, input int e);
    params.targetSpeedValue = 32'h0098_9680;
    params.drivePulseCount = n;
    nPlus = 0;
    cmd(c);
    waitFor(2, 1000);
    params.drivePulseCount = -1;
    countWrite = 1;
    @(negedge clk);
    countWrite = 0;
    @(negedge clk);
    params.drivePulseCount = m;
    countWrite = 1;
    @(negedge clk);
    countWrite = 0;
    waitFor(0, 5000);
    chk(nPlus, e);
    expPos = expPos + e;
  endtask
  // Continuous drives: stop by command and by the stop input.
  task automatic contRun;
    params.targetSpeedValue = 32'h0131_2D00;
    nPlus = 0;
    nMinus = 0;
    cmd(CMD_CONT_PLUS);
    repeat (400) @(negedge clk);
    chk(busy, 1);
    chk(nPlus >= 30, 1);
    cmd(CMD_INSTANT_STOP);
    waitFor(0, 4);
    contInterp = 1;
    cmd(CMD_CONT_MINUS);
    params.targetSpeedValue = 32'h05F5_E100;
    speedWrite = 1;
    @(negedge clk);
    speedWrite = 0;
    repeat (60) @(negedge clk);
    chk(gap, 10);
    contInterp = 0;
    speedWrite = 1;
    @(negedge clk);
    speedWrite = 0;
    repeat (20) @(negedge clk);
    chk(gap, 2);
    chk(dirMinus, 1);
    extStop = 1;
    waitFor(0, 10);
    extStop = 0;
    expPos = expPos + nPlus - nMinus;
    chk(logicalPos, expPos);
  endtask
  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    chk(busy, 0);
    chk(logicalPos, 0);
    nrst = 1;
    expPos = 0;
    params.startSpeedValue = 32'h0098_9680;
    params.accelDecelRate = 32'h003D_0900;
    params.targetSpeedValue = 32'h05F5_E100;
    fixedRun(CMD_REL, 3, 3, 0);
    fixedRun(CMD_REL, -2, 0, 2);
    fixedRun(CMD_CREL, 2, 0, 2);
    fixedRun(CMD_CREL, -1, 1, 0);
    fixedRun(CMD_ABS, 5, 5, 0);
    fixedRun(CMD_ABS, -2, 0, 7);
    params.drivePulseCount = 0;
    cmd(CMD_REL);
    chk(busy, 0);
    params.splitEn = 1;
    params.splitInterval = 32'h0000_0003;
    fixedRun(CMD_REL, 9, 9, 0);
    chk(nSplit, 3);
    params.splitEn = 0;
    rampRun(0, 12, 40);
    rampRun(1, 2, 8);
    overrideRun(CMD_REL, 10, 5, 5);
    overrideRun(CMD_ABS, expPos + 6, 3, 6);
    contRun();
    close_out();
  end
endmodule
`default_nettype wire
